// ### isp_pkg.sv
// isp_pkg: shared constants and carrier types for the interrupt
// source prioritisation and vectoring block.
// assumes a 16-bit address space with vectors at the top of memory.
package isp_pkg;

   ////////////////////////////////////////////////////////////////////
   // source map
   localparam int NUM_LVL = 20;          // hardware levels 1..20
   localparam int NUM_RAW = 34;          // individual flag/enable pairs
   localparam int LVL_W = 5;

   // level of each raw flag; several flags share one level
   localparam logic [4:0] RAW_LVL [NUM_RAW] = '{
      5'h01,                             // external request pin
      5'h02,                             // clock lock change
      5'h03, 5'h04, 5'h05,               // timer 1 ch0, ch1, overflow
      5'h06, 5'h07, 5'h08,               // timer 2 ch0, ch1, overflow
      5'h09, 5'h09, 5'h09,               // serial rx full, overrun, fault
      5'h0A,                             // serial tx empty
      5'h0B, 5'h0B, 5'h0B, 5'h0B,        // uart error group
      5'h0C, 5'h0C,                      // uart rx full, idle
      5'h0D, 5'h0D,                      // uart tx empty, tx complete
      5'h0E,                             // keypad
      5'h0F,                             // adc
      5'h10,                             // periodic tick
      5'h11,                             // can wakeup
      5'h12, 5'h12, 5'h12, 5'h12, 5'h12, 5'h12, // can error group
      5'h13,                             // can receive
      5'h14, 5'h14, 5'h14                // can transmit buffers
   };

   ////////////////////////////////////////////////////////////////////
   // vectors
   localparam logic [15:0] RESET_VEC = 16'hFFFE;
   localparam logic [15:0] TRAP_VEC = 16'hFFFC;
   localparam logic [15:0] LOW_VEC = 16'hFFD4;   // level 20 pair
   localparam logic [15:0] VEC_STEP = 16'h0002;
   localparam logic [15:0] HW_RET_ADJ = 16'h0001;

   ////////////////////////////////////////////////////////////////////
   // register map (byte addresses, one word each)
   localparam logic [7:0] CTRL_OFS = 8'h00;   // bit0 global mask
   localparam logic [7:0] PEND_OFS = 8'h04;   // bits 20:1 level pending
   localparam logic [7:0] LAST_OFS = 8'h08;   // last entry record
   localparam int MASK_BIT = 0;
   localparam int LAST_VEC_LSB = 0;           // [15:0] vector
   localparam int LAST_LVL_LSB = 16;          // [20:16] level
   localparam int LAST_TRAP_BIT = 24;         // entry was a trap
   localparam logic MASK_RST = 1'b1;          // masked out of reset

   ////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      ISP_BOOT,
      ISP_IDLE,
      ISP_STACK,
      ISP_VECT
   } isp_state_e;

   // which cpu registers the sequencer must push; index high is absent
   typedef struct packed {
      logic pc_lo;
      logic pc_hi;
      logic idx_lo;
      logic acc;
      logic ccr;
   } isp_stack_s;

   typedef struct packed {
      logic [15:0] vec;
      logic [4:0] lvl;
      logic trap;
   } isp_entry_s;

endpackage

// ### isp_arbiter.sv
// isp_arbiter: folds flag/enable pairs into per-level requests and
// picks the most urgent one with its vector.
// assumes flags and enables are levels synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none

module isp_arbiter #(
   parameter int NUM_RAW = isp_pkg::NUM_RAW,
   parameter int NUM_LVL = isp_pkg::NUM_LVL
) (
   input wire logic [NUM_RAW-1:0] flag_i,
   input wire logic [NUM_RAW-1:0] en_i,
   output logic [NUM_LVL:1] pend_o,
   output logic any_o,
   output logic [4:0] lvl_o,
   output logic [15:0] vec_o
);

   ////////////////////////////////////////////////////////////////////
   // one request per level; shared groups or together
   genvar g;
   generate
      for (g = 1; g <= NUM_LVL; g++) begin : g_lvl
         logic [NUM_RAW-1:0] hit;
         always_comb begin
            for (int r = 0; r < NUM_RAW; r++) begin
               // any enabled flag of the group raises it
               hit[r] = flag_i[r] & en_i[r] &
                        (isp_pkg::RAW_LVL[r] == 5'(g));
            end
         end
         assign pend_o[g] = |hit;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // lowest number wins; scan from the bottom so the top overwrites
   always_comb begin
      any_o = 1'b0;
      lvl_o = 5'h00;
      for (int l = NUM_LVL; l >= 1; l--) begin
         if (pend_o[l]) begin
            any_o = 1'b1;
            lvl_o = 5'(l);
         end
      end
      // one pair per step below the trap pair
      vec_o = isp_pkg::TRAP_VEC -
              16'(isp_pkg::VEC_STEP * 16'(lvl_o));
   end

endmodule

`default_nettype wire

// ### isp_ctrl.sv
// isp_ctrl: interrupt prioritisation, masking, entry sequencing and
// vectoring, with a classic wishbone slave for its control registers.
// assumes the cpu sequencer reports instruction ends, trap opcodes,
// and acknowledges stacking; peripheral flags arrive as levels.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - trap instruction always enters, ignoring all masks
// - trap pushes current pc unchanged
// - hardware entry pushes pc minus one
// - break match forces trap instruction execution
// - global mask blocks all but trap
// - priority numeric, zero highest, pin one
// - fixed descending two-byte vector per group
// - at instruction end serve highest pending
// - entry sets global mask, no preemption
// - stack cpu registers except index high
// - never abort instruction; wait for completion
module isp_ctrl #(
   parameter int NUM_RAW = isp_pkg::NUM_RAW,
   parameter int NUM_LVL = isp_pkg::NUM_LVL
) (
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // peripheral flag/enable pairs
   input wire logic [NUM_RAW-1:0] src_flag_i,
   input wire logic [NUM_RAW-1:0] src_en_i,
   // cpu sequencer side
   input wire logic instr_done_i,
   input wire logic trap_exec_i,
   input wire logic break_match_i,
   input wire logic [15:0] pc_i,
   input wire logic mask_wr_i,
   input wire logic mask_val_i,
   input wire logic stack_done_i,
   input wire logic fetch_done_i,
   output logic mask_o,
   output logic force_trap_o,
   output logic stack_req_o,
   output isp_pkg::isp_stack_s stack_sel_o,
   output logic [15:0] ret_addr_o,
   output logic vec_req_o,
   output logic [15:0] vec_addr_o
);

   ////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      isp_pkg::isp_state_e st;
      logic mask;                  // global mask bit
      logic force_trap;            // break asks for a trap opcode
      logic stack_req;
      isp_pkg::isp_stack_s stack_sel;
      logic [15:0] ret;
      logic vec_req;
      isp_pkg::isp_entry_s last;   // most recent entry
      logic ack;
      logic [31:0] rdat;
   } isp_regs_s;

   isp_regs_s cur_ff;    // registered state
   isp_regs_s nxt_cur;   // next state

   logic [NUM_LVL:1] pend;   // per-level request
   logic any_pend;           // at least one level asking
   logic [4:0] win_lvl;      // most urgent level
   logic [15:0] win_vec;     // its vector pair
   logic bus_req;            // fresh wishbone request
   logic take_hw;            // hardware entry accepted
   logic take_trap;          // trap entry accepted

   ////////////////////////////////////////////////////////////////////
   // request folding and selection
   isp_arbiter #(
      .NUM_RAW(NUM_RAW),
      .NUM_LVL(NUM_LVL)
   ) u_arb (
      .flag_i(src_flag_i),
      .en_i(src_en_i),
      .pend_o(pend),
      .any_o(any_pend),
      .lvl_o(win_lvl),
      .vec_o(win_vec)
   );

   ////////////////////////////////////////////////////////////////////
   // entry decisions, only sampled on an instruction boundary
   always_comb begin
      // trap ignores the mask and every enable
      take_trap = (cur_ff.st == isp_pkg::ISP_IDLE) & instr_done_i &
                  trap_exec_i;
      // hardware waits for the boundary and a clear mask
      take_hw = (cur_ff.st == isp_pkg::ISP_IDLE) & instr_done_i &
                ~trap_exec_i & ~cur_ff.mask & any_pend;
      bus_req = cyc_i & stb_i & ~cur_ff.ack;
   end

   ////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.vec_req = 1'b0;
      nxt_cur.ack = 1'b0;

      // break match turns the next opcode into a trap
      nxt_cur.force_trap = break_match_i;

      // cpu writes of the mask (return, clear, set instructions)
      if (mask_wr_i) begin
         nxt_cur.mask = mask_val_i;
      end

      // wishbone slave: answer one cycle after the strobe
      if (bus_req) begin
         nxt_cur.ack = 1'b1;
         nxt_cur.rdat = 32'h0000_0000;
         case (adr_i)
            isp_pkg::CTRL_OFS: begin
               if (we_i && sel_i[0]) begin
                  nxt_cur.mask = dat_i[isp_pkg::MASK_BIT];
               end
               nxt_cur.rdat[isp_pkg::MASK_BIT] = cur_ff.mask;
            end
            isp_pkg::PEND_OFS: begin
               // read-only view of the level requests
               nxt_cur.rdat[NUM_LVL:1] = pend;
            end
            isp_pkg::LAST_OFS: begin
               nxt_cur.rdat[isp_pkg::LAST_VEC_LSB +: 16] = cur_ff.last.vec;
               nxt_cur.rdat[isp_pkg::LAST_LVL_LSB +: 5] = cur_ff.last.lvl;
               nxt_cur.rdat[isp_pkg::LAST_TRAP_BIT] = cur_ff.last.trap;
            end
            default: begin
               // unmapped: acknowledged, reads zero, writes dropped
               nxt_cur.rdat = 32'h0000_0000;
            end
         endcase
      end

      case (cur_ff.st)
         isp_pkg::ISP_BOOT: begin
            // first fetch after reset goes through the reset pair
            nxt_cur.vec_req = 1'b1;
            nxt_cur.last.vec = isp_pkg::RESET_VEC;
            nxt_cur.last.lvl = 5'h00;
            nxt_cur.last.trap = 1'b0;
            nxt_cur.st = isp_pkg::ISP_VECT;
         end
         isp_pkg::ISP_IDLE: begin
            if (take_trap) begin
               nxt_cur.ret = pc_i;
               nxt_cur.last.vec = isp_pkg::TRAP_VEC;
               nxt_cur.last.lvl = 5'h00;
               nxt_cur.last.trap = 1'b1;
            end else if (take_hw) begin
               nxt_cur.ret = pc_i - isp_pkg::HW_RET_ADJ;
               nxt_cur.last.vec = win_vec;
               nxt_cur.last.lvl = win_lvl;
               nxt_cur.last.trap = 1'b0;
            end
            if (take_trap || take_hw) begin
               // set wins over any write landing this cycle
               nxt_cur.mask = 1'b1;
               nxt_cur.stack_req = 1'b1;
               nxt_cur.stack_sel = '{pc_lo: 1'b1, pc_hi: 1'b1,
                                     idx_lo: 1'b1, acc: 1'b1,
                                     ccr: 1'b1};
               nxt_cur.st = isp_pkg::ISP_STACK;
            end
         end
         isp_pkg::ISP_STACK: begin
            // hold the push request until the sequencer is done
            if (stack_done_i) begin
               nxt_cur.stack_req = 1'b0;
               nxt_cur.vec_req = 1'b1;
               nxt_cur.st = isp_pkg::ISP_VECT;
            end
         end
         isp_pkg::ISP_VECT: begin
            // vector stays valid until the fetch completes
            if (fetch_done_i) begin
               nxt_cur.st = isp_pkg::ISP_IDLE;
            end else begin
               nxt_cur.vec_req = 1'b1;
            end
         end
         default: begin
            nxt_cur.st = isp_pkg::ISP_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state register; reset sets the global mask (traps still enter) and vectors to reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_ff <= '0;
         cur_ff.st <= isp_pkg::ISP_BOOT;
         cur_ff.mask <= isp_pkg::MASK_RST;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs straight from the state record
   assign dat_o = cur_ff.rdat;
   assign ack_o = cur_ff.ack;
   assign mask_o = cur_ff.mask;
   assign force_trap_o = cur_ff.force_trap;
   assign stack_req_o = cur_ff.stack_req;
   assign stack_sel_o = cur_ff.stack_sel;
   assign ret_addr_o = cur_ff.ret;
   assign vec_req_o = cur_ff.vec_req;
   assign vec_addr_o = cur_ff.last.vec;

endmodule

`default_nettype wire

// ### isp_ctrl_properties.sv
// isp_ctrl_properties: timing checks on the entry sequencer ports.
// assumes the cpu side keeps the instr, stack, fetch order of requests.
`timescale 1ns/10ps
`default_nettype none
module isp_ctrl_properties #(
   parameter int NUM_RAW = isp_pkg::NUM_RAW
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NUM_RAW-1:0] src_flag_i,
   input wire logic [NUM_RAW-1:0] src_en_i,
   input wire logic instr_done_i,
   input wire logic trap_exec_i,
   input wire logic break_match_i,
   input wire logic [15:0] pc_i,
   input wire logic stack_done_i,
   input wire logic mask_o,
   input wire logic force_trap_o,
   input wire logic stack_req_o,
   input wire isp_pkg::isp_stack_s stack_sel_o,
   input wire logic [15:0] ret_addr_o,
   input wire logic vec_req_o,
   input wire logic [15:0] vec_addr_o
);
   logic [1:0] up_ff; // boot has had two edges to settle
   logic trap_ff; // last idle instruction end was a trap
   logic idle; // sequencer waits for an instruction end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   /////////////////////////////////////////////////////////////////////
   // idle proxy; the first edges after reset are skipped, boot is pending
   assign idle = up_ff[1] & ~stack_req_o & ~vec_req_o;
   always_ff @(posedge clk_i) begin
      up_ff <= rst_i ? 2'h0 : {up_ff[0], 1'b1};
      trap_ff <= rst_i ? 1'b0 : (idle && instr_done_i) ? trap_exec_i : trap_ff;
   end
   /////////////////////////////////////////////////////////////////////
   sequence s_trap_end;
      idle && instr_done_i && trap_exec_i;
   endsequence
   sequence s_hw_end;
      idle && instr_done_i && !trap_exec_i && !mask_o
         && (|(src_flag_i & src_en_i));
   endsequence
   sequence s_stack_end;
      stack_req_o && stack_done_i;
   endsequence
   a_trap_enters:
   assert property (s_trap_end |=> stack_req_o && ret_addr_o == $past(pc_i))
      else $error("trap entry missing or wrong return address");
   a_hw_ret:
   assert property (s_hw_end |=> stack_req_o
      && ret_addr_o == $past(pc_i) - 16'h0001)
      else $error("hardware entry missing or wrong return address");
   a_mask_blocks:
   assert property (idle && instr_done_i && !trap_exec_i && mask_o
      |=> !stack_req_o) else $error("masked request was taken");
   a_no_midentry:
   assert property (idle && !instr_done_i |=> !stack_req_o)
      else $error("entry began before instruction end");
   a_break_forces:
   assert property ($rose(break_match_i) |=> $rose(force_trap_o))
      else $error("break match did not force a trap");
   a_stack_regs:
   assert property (stack_req_o |-> stack_sel_o == 5'h1F)
      else $error("wrong register set stacked");
   a_entry_masks:
   assert property (stack_req_o |-> mask_o)
      else $error("mask clear during entry");
   a_stack_to_vec:
   assert property (s_stack_end |=> !stack_req_o && vec_req_o)
      else $error("vector fetch did not follow stacking");
   a_trap_vector:
   assert property ($rose(vec_req_o) && trap_ff |-> vec_addr_o == 16'hFFFC)
      else $error("trap vector wrong");
   a_hw_vector:
   assert property ($rose(vec_req_o) && !trap_ff && $past(stack_req_o)
      |-> vec_addr_o inside {[16'hFFD4:16'hFFFA]} && !vec_addr_o[0])
      else $error("hardware vector out of range");
endmodule
bind isp_ctrl isp_ctrl_properties #(.NUM_RAW(NUM_RAW)) u_props (
   .clk_i(clk_i), .rst_i(rst_i), .src_flag_i(src_flag_i),
   .src_en_i(src_en_i), .instr_done_i(instr_done_i),
   .trap_exec_i(trap_exec_i), .break_match_i(break_match_i), .pc_i(pc_i),
   .stack_done_i(stack_done_i), .mask_o(mask_o),
   .force_trap_o(force_trap_o), .stack_req_o(stack_req_o),
   .stack_sel_o(stack_sel_o), .ret_addr_o(ret_addr_o),
   .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o));
`default_nettype wire

// ### isp_seq_model.sv
// isp_seq_model: cpu sequencer stand-in for one push or fetch phase.
// assumes req_i stays high until the cycle after done_o is seen.
`timescale 1ns/10ps
`default_nettype none
module isp_seq_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic req_i,
   input wire logic [1:0] lat_i,
   output logic done_o
);
   logic [1:0] cnt_ff; // cycles waited; lat_i 0 answers promptly
   /////////////////////////////////////////////////////////////////////
   // one-cycle done pulse after lat_i idle cycles of request
   always_ff @(posedge clk_i) begin
      if (rst_i || done_o) begin
         done_o <= 1'b0;
         cnt_ff <= 2'h0;
      end else if (req_i) begin
         if (cnt_ff == lat_i) done_o <= 1'b1;
         else cnt_ff <= cnt_ff + 2'h1;
      end
   end
endmodule
`default_nettype wire

// ### test_interrupt_source_priority_vectoring.sv
// bench: drives bus, flags and instruction ends into isp_ctrl.
// assumes the sequencer model answers stack and vector requests.
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_source_priority_vectoring;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, done = 1'b0, trap = 1'b0;
   logic brk = 1'b0, mwr = 1'b0, ack_o, mask_o, ftrap, sreq, vreq, sdn, fdn;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0, dat_o, q;
   logic [33:0] flag = '0, en = '0;
   logic [15:0] pc = 16'h0000, ret, vec, ev;
   logic [1:0] lat = 2'h0; // partner latency, varied per entry
   logic mval = 1'b0; // value of a cpu mask write
   logic [4:0] ssel; // register set picked for stacking
   int errors = 0, n_tests = 0, r;
   always #2.5 clk_i = ~clk_i;
   isp_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o),
      .ack_o(ack_o), .src_flag_i(flag), .src_en_i(en), .instr_done_i(done),
      .trap_exec_i(trap), .break_match_i(brk), .pc_i(pc), .mask_wr_i(mwr),
      .mask_val_i(mval), .stack_done_i(sdn), .fetch_done_i(fdn),
      .mask_o(mask_o), .force_trap_o(ftrap), .stack_req_o(sreq),
      .stack_sel_o(ssel), .ret_addr_o(ret), .vec_req_o(vreq),
      .vec_addr_o(vec));
   isp_seq_model u_stk (.clk_i(clk_i), .rst_i(rst_i), .req_i(sreq),
      .lat_i(lat), .done_o(sdn));
   isp_seq_model u_fch (.clk_i(clk_i), .rst_i(rst_i), .req_i(vreq),
      .lat_i(~lat), .done_o(fdn));
   /////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         $display("Error t=%0t got %h exp %h", $time, g, e);
         errors++;
      end
   endtask
   // bounded wait, sampled mid-cycle so edge updates have landed
   task wfor(input int s, input logic v);
      for (int i = 0; i < 64; i++) begin
         @(negedge clk_i);
         if ((s == 0 ? sreq : s == 1 ? vreq : ack_o) === v) return;
      end
      errors++;
      give_verdict();
   endtask
   // classic single cycle; held until the rising edge that sees ack,
   // read data is taken at that same edge, then the request drops
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (int i = 0; i < 64; i++) begin
         @(posedge clk_i);
         if (ack_o === 1'b1) begin
            q = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            we <= 1'b0;
            return;
         end
      end
      errors++;
      give_verdict();
   endtask
   // one instruction end, then follow the whole entry
   task enter(input logic t, input logic [15:0] p, input logic [15:0] er);
      @(posedge clk_i);
      done <= 1'b1;
      trap <= t;
      pc <= p;
      @(posedge clk_i);
      done <= 1'b0;
      trap <= 1'b0;
      wfor(0, 1'b1);
      chk({16'h0, ret}, {16'h0, er});
      chk({31'h0, mask_o}, 32'h1);
      chk({27'h0, ssel}, 32'h1F);
      wfor(1, 1'b1);
      chk({16'h0, vec}, {16'h0, ev});
      wfor(1, 1'b0);
   endtask
   // instruction end that must not start an entry
   task quiet();
      @(posedge clk_i);
      done <= 1'b1;
      @(posedge clk_i);
      done <= 1'b0;
      repeat (3) @(negedge clk_i);
      chk({31'h0, sreq}, 32'h0);
   endtask
   task give_verdict();
      $display("errors=%0d tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   /////////////////////////////////////////////////////////////////////
   // main sequence: boot, trap, masking, priority, every source
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      wfor(1, 1'b1);
      chk({16'h0, vec}, {16'h0, isp_pkg::RESET_VEC});
      wfor(1, 1'b0);
      wb(1'b0, isp_pkg::CTRL_OFS, 32'h0);
      chk(q, 32'h1);
      @(posedge clk_i);
      brk <= 1'b1;
      @(posedge clk_i);
      brk <= 1'b0;
      @(negedge clk_i);
      chk({31'h0, ftrap}, 32'h1);
      ev = isp_pkg::TRAP_VEC;
      enter(1'b1, 16'h1234, 16'h1234);
      @(posedge clk_i);
      flag <= '1;
      en <= '1;
      quiet();
      @(posedge clk_i);
      en <= '0;
      wb(1'b1, isp_pkg::CTRL_OFS, 32'h0);
      quiet();
      @(posedge clk_i);
      flag <= 34'h2_0010_0010;
      en <= 34'h2_0010_0010;
      wb(1'b0, isp_pkg::PEND_OFS, 32'h0);
      chk(q, 32'h0010_4020);
      ev = 16'hFFF2;
      enter(1'b0, 16'h0000, 16'hFFFF);
      wb(1'b0, isp_pkg::CTRL_OFS, 32'h0);
      chk(q, 32'h1);
      wb(1'b0, isp_pkg::LAST_OFS, 32'h0);
      chk(q, 32'h0005_FFF2);
      wb(1'b0, 8'h0C, 32'h0);
      chk(q, 32'h0);
      for (r = 0; r < isp_pkg::NUM_RAW; r++) begin
         @(posedge clk_i);
         flag <= 34'h1 << r;
         en <= 34'h1 << r;
         mwr <= 1'b1;
         lat <= r[1:0];
         ev = isp_pkg::TRAP_VEC - {10'h0, isp_pkg::RAW_LVL[r], 1'b0};
         @(posedge clk_i);
         mwr <= 1'b0;
         enter(1'b0, 16'h0100 + r[15:0], 16'h00FF + r[15:0]);
      end
      // cpu clears then sets the mask; a pending source must then wait
      @(posedge clk_i);
      mwr <= 1'b1;
      mval <= 1'b0;
      @(posedge clk_i);
      mval <= 1'b1;
      @(posedge clk_i);
      mwr <= 1'b0;
      quiet();
      chk({31'h0, mask_o}, 32'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
